// [rtl/tcr_pkg.sv]
package tcr_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  TCR_OFS_PRIMARY   = 8'h00;
   localparam logic [7:0]  TCR_OFS_SECONDARY = 8'h04;
   localparam logic [15:0] TCR_PRIMARY_RST   = 16'h0000;
   localparam logic [15:0] TCR_SECONDARY_RST = 16'h0000;
   localparam logic [15:0] TCR_PRIMARY_MASK  = 16'h038f;
   localparam logic [15:0] TCR_SECONDARY_MASK = 16'h030d;

   // ---------------------------------------------------------------
   // Primary register fields
   // ---------------------------------------------------------------
   localparam int TCR_B_COUNT_RUN     = 0;
   localparam int TCR_B_UPDATE_BLOCK  = 1;
   localparam int TCR_B_UPDATE_SRC    = 2;
   localparam int TCR_B_SINGLE_PULSE  = 3;
   localparam int TCR_B_RELOAD_BUF    = 7;
   localparam int TCR_B_DIV_LO        = 8;
   localparam int TCR_B_DIV_HI        = 9;

   // ---------------------------------------------------------------
   // Secondary register fields
   // ---------------------------------------------------------------
   localparam int TCR_B_CTRL_PRELOAD  = 0;
   localparam int TCR_B_CTRL_UPD_SEL  = 2;
   localparam int TCR_B_DMA_SEL       = 3;
   localparam int TCR_B_PRIMARY_IDLE  = 8;
   localparam int TCR_B_COMPL_IDLE    = 9;

   // ---------------------------------------------------------------
   // Divider and lock codes, field widths
   // ---------------------------------------------------------------
   localparam logic [1:0] TCR_DIV_1 = 2'h0;
   localparam logic [1:0] TCR_DIV_2 = 2'h1;
   localparam logic [1:0] TCR_DIV_4 = 2'h2;
   localparam logic [1:0] TCR_DIV_RSV = 2'h3;
   localparam logic [1:0] TCR_LOCK_OFF = 2'h0;
   localparam int TCR_CTRL_W = 4;
   localparam int TCR_VAL_W = 16;
endpackage : tcr_pkg

// [rtl/tcr_div_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface tcr_div_if;
   logic [1:0] div_sel;
   logic       sample_en;
   modport ctrl (output div_sel, input sample_en);
   modport div  (input div_sel, output sample_en);
endinterface : tcr_div_if
`default_nettype wire

// [rtl/tcr_sample_div.sv]
`timescale 1ns/10ps
`default_nettype none
module tcr_sample_div
   import tcr_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // Divider control
   tcr_div_if.div    dv
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [1:0] sel_q;
   logic       wrap;

   // ---------------------------------------------------------------
   // Period end per setting; new setting taken only at a period end
   // ---------------------------------------------------------------
   assign wrap = (sel_q == TCR_DIV_1) ||
                 (sel_q == TCR_DIV_2 && cnt_q == 2'h1) ||
                 (sel_q == TCR_DIV_4 && cnt_q == 2'h3) ||
                 (sel_q == TCR_DIV_RSV);                    // [R08]
   assign cnt_d = wrap ? 2'h0 : cnt_q + 2'h1;
   assign dv.sample_en = wrap;                              // [R17]

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 2'h0;
         sel_q <= TCR_DIV_1;
      end else begin
         cnt_q <= cnt_d;
         if (wrap) begin
            sel_q <= dv.div_sel;                            // [R17]
         end
      end
   end
endmodule : tcr_sample_div
`default_nettype wire

// [rtl/tcr_control.sv]
// Summary of operation
// R01: Bit 0 runs or stops the counter
// R02: Trigger mode may set run bit
// R03: Update block bit suppresses update events
// R04: Update event loads buffered values into active
// R05: Source select limits update request causes
// R06: Single pulse clears run at update
// R07: Reload buffering defers reload until update
// R08: Divider field picks 1, 2, 4 periods
// R09: Both registers reset zero, offsets 0/4
// R10: Control preload defers channel control bits
// R11: Update select adds trigger rising edge
// R12: DMA select picks compare or update
// R13: Primary idle level from bit 8
// R14: Complement idle level from bit 9
// R15: Lock level protects idle level bits
// R16: Reserved bits read zero, ignore writes
// R17: Sample clock enable glitch-free from divider
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tcr_control
   import tcr_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_i,
   // Register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [15:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [15:0]           rdata_o,
   // Counter events, same clock
   input  wire logic                  overflow_i,
   input  wire logic                  update_generate_bit_i,
   input  wire logic                  slave_update_i,
   input  wire logic                  trigger_start_i,
   input  wire logic                  commutation_generate_i,
   input  wire logic                  compare_event_i,
   input  wire logic [1:0]            lock_level_i,
   input  wire logic                  main_output_on_i,
   // Trigger pin
   input  wire logic                  trigger_input_i,
   // Shadow values written by software
   input  wire logic [TCR_VAL_W-1:0]  reload_value_i,
   input  wire logic                  reload_write_i,
   input  wire logic [TCR_VAL_W-1:0]  prescale_value_i,
   input  wire logic [TCR_VAL_W-1:0]  channel_compare_value_i,
   input  wire logic [TCR_CTRL_W-1:0] channel_ctrl_i,
   // Block outputs
   output logic                       count_run_o,
   output logic                       update_event_signal_o,
   output logic                       update_request_o,
   output logic                       channel_dma_request_o,
   output logic                       sample_en_o,
   output logic [TCR_VAL_W-1:0]       reload_active_o,
   output logic [TCR_VAL_W-1:0]       prescale_active_o,
   output logic [TCR_VAL_W-1:0]       compare_active_o,
   output logic [TCR_CTRL_W-1:0]      channel_ctrl_active_o,
   output logic                       primary_channel_output_o,
   output logic                       complement_channel_output_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [15:0]           prim_q;
   logic [15:0]           sec_q;
   logic [15:0]           rdata_q;
   logic [2:0]            trig_sync_q;
   logic [TCR_VAL_W-1:0]  reload_q;
   logic [TCR_VAL_W-1:0]  presc_q;
   logic [TCR_VAL_W-1:0]  cmp_q;
   logic [TCR_CTRL_W-1:0] cctl_q;
   logic                  upd_q;
   logic                  ureq_q;
   logic                  dreq_q;
   logic                  pidle_q;
   logic                  cidle_q;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic        sel_prim;
   logic        sel_sec;
   logic        wr_prim;
   logic        wr_sec;
   logic        locked;
   logic [15:0] prim_wval;
   logic [15:0] sec_wval;
   logic [15:0] rd_mux;

   assign sel_prim  = (addr_i == TCR_OFS_PRIMARY);           // [R09]
   assign sel_sec   = (addr_i == TCR_OFS_SECONDARY);         // [R09]
   assign wr_prim   = wr_i && sel_prim;
   assign wr_sec    = wr_i && sel_sec;
   assign locked    = (lock_level_i != TCR_LOCK_OFF);
   assign prim_wval = wdata_i & TCR_PRIMARY_MASK;            // [R16]
   assign rd_mux    = sel_prim ? prim_q :
                      sel_sec  ? sec_q  : 16'h0000;          // [R16]

   // Idle bits keep old value while locked
   assign sec_wval  = locked ?
      ((wdata_i & TCR_SECONDARY_MASK & 16'hfcff) | (sec_q & 16'h0300)) :
      (wdata_i & TCR_SECONDARY_MASK);                        // [R15]

   // ---------------------------------------------------------------
   // Update event logic
   // ---------------------------------------------------------------
   logic update_block;
   logic update_src;
   logic upd_raw;
   logic upd_ev;
   logic req_ev;
   logic trig_rise;
   logic ctrl_xfer;
   logic reload_now;

   assign update_block = prim_q[TCR_B_UPDATE_BLOCK];
   assign update_src   = prim_q[TCR_B_UPDATE_SRC];
   assign upd_raw   = overflow_i || update_generate_bit_i || slave_update_i;
   assign upd_ev    = !update_block && upd_raw;               // [R03]
   assign req_ev    = upd_ev && (!update_src || overflow_i);  // [R05]
   assign trig_rise = trig_sync_q[1] && !trig_sync_q[2];
   assign ctrl_xfer = commutation_generate_i ||
                      (sec_q[TCR_B_CTRL_UPD_SEL] && trig_rise); // [R11]
   assign reload_now = !prim_q[TCR_B_RELOAD_BUF] && reload_write_i; // [R07]

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   tcr_div_if div_bus ();
   assign div_bus.div_sel = prim_q[TCR_B_DIV_HI:TCR_B_DIV_LO];  // [R08]
   assign sample_en_o     = div_bus.sample_en;

   tcr_sample_div u_div (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .dv        (div_bus.div)
   );

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prim_q <= TCR_PRIMARY_RST;                          // [R09]
         sec_q  <= TCR_SECONDARY_RST;                        // [R09]
      end else begin
         if (wr_prim) begin
            prim_q <= prim_wval;                             // [R01]
         end
         if (trigger_start_i) begin
            prim_q[TCR_B_COUNT_RUN] <= 1'b1;                 // [R02]
         end
         if (upd_ev && prim_q[TCR_B_SINGLE_PULSE]) begin
            prim_q[TCR_B_COUNT_RUN] <= 1'b0;                 // [R06]
         end
         if (wr_sec) begin
            sec_q <= sec_wval;
         end
      end
   end

   // ---------------------------------------------------------------
   // Active values and requests
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         reload_q <= '0;
         presc_q  <= '0;
         cmp_q    <= '0;
         cctl_q   <= '0;
      end else begin
         if (upd_ev || reload_now) begin
            reload_q <= reload_value_i;                      // [R04] [R07]
         end
         if (upd_ev) begin
            presc_q <= prescale_value_i;                     // [R04]
            cmp_q   <= channel_compare_value_i;              // [R04]
         end
         if (!sec_q[TCR_B_CTRL_PRELOAD] || ctrl_xfer) begin
            cctl_q <= channel_ctrl_i;                        // [R10]
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         trig_sync_q <= 3'h0;
         upd_q       <= 1'b0;
         ureq_q      <= 1'b0;
         dreq_q      <= 1'b0;
         pidle_q     <= 1'b0;
         cidle_q     <= 1'b0;
         rdata_q     <= 16'h0000;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], trigger_input_i};
         upd_q       <= upd_ev;
         ureq_q      <= req_ev;
         dreq_q      <= sec_q[TCR_B_DMA_SEL] ? req_ev : compare_event_i; // [R12]
         pidle_q     <= sec_q[TCR_B_PRIMARY_IDLE];           // [R13]
         cidle_q     <= sec_q[TCR_B_COMPL_IDLE];             // [R14]
         if (rd_i) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign rdata_o                     = rdata_q;
   assign count_run_o                 = prim_q[TCR_B_COUNT_RUN]; // [R01]
   assign update_event_signal_o       = upd_q;
   assign update_request_o            = ureq_q;
   assign channel_dma_request_o       = dreq_q;
   assign reload_active_o             = reload_q;
   assign prescale_active_o           = presc_q;
   assign compare_active_o            = cmp_q;
   assign channel_ctrl_active_o       = cctl_q;
   assign primary_channel_output_o    = main_output_on_i ? 1'b0 : pidle_q;  // [R13]
   assign complement_channel_output_o = main_output_on_i ? 1'b0 : cidle_q;  // [R14]
endmodule : tcr_control
`default_nettype wire

// [bench/tcr_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module tcr_monitor
   import tcr_pkg::*;
(
   // Clock, reset, register port
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   // Events and levels
   input wire logic        overflow_i,
   input wire logic        update_generate_bit_i,
   input wire logic        slave_update_i,
   input wire logic        trigger_start_i,
   input wire logic        compare_event_i,
   input wire logic [1:0]  lock_level_i,
   input wire logic        main_output_on_i,
   // Block outputs
   input wire logic        count_run_o,
   input wire logic        update_event_signal_o,
   input wire logic        update_request_o,
   input wire logic        channel_dma_request_o,
   input wire logic        sample_en_o,
   input wire logic        primary_channel_output_o,
   input wire logic        complement_channel_output_o
);
   // ------------------------------
   // Shadow of software settings
   // ------------------------------
   logic [15:0] pri_q;
   logic [15:0] sec_q;
   wire logic   cause = overflow_i | update_generate_bit_i | slave_update_i;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pri_q <= 16'h0000;
         sec_q <= 16'h0000;
      end else if (wr_i && addr_i == TCR_OFS_PRIMARY) begin
         pri_q <= wdata_i & TCR_PRIMARY_MASK;
      end else if (wr_i && addr_i == TCR_OFS_SECONDARY) begin
         sec_q <= {6'h00, (lock_level_i == TCR_LOCK_OFF) ? wdata_i[9:8] : sec_q[9:8], wdata_i[7:0] & 8'h0d};
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_gap4;
      !sample_en_o [*3] ##1 sample_en_o;
   endsequence
   a_run_write: assert property (wr_i && addr_i == TCR_OFS_PRIMARY && !cause && !trigger_start_i
      |=> count_run_o == $past(wdata_i[0])) else $error("run bit differs from write");
   a_update_fires: assert property (cause && !pri_q[1] |=> update_event_signal_o)
      else $error("update event missing");
   a_update_blocked: assert property (pri_q[1] |=> !update_event_signal_o)
      else $error("update event while blocked");
   a_request_src: assert property (cause && !pri_q[1]
      |=> update_request_o == ($past(overflow_i) || !$past(pri_q[2]))) else $error("update request source wrong");
   a_pulse_stop: assert property (cause && !pri_q[1] && pri_q[3] |=> !count_run_o)
      else $error("single pulse did not stop");
   a_dma_compare: assert property (compare_event_i && !sec_q[3] |=> channel_dma_request_o)
      else $error("compare dma request missing");
   a_idle_level: assert property (!main_output_on_i |-> primary_channel_output_o == $past(sec_q[8])
      && complement_channel_output_o == $past(sec_q[9])) else $error("idle level wrong");
   a_div_four: assert property (sample_en_o && pri_q[9:8] == TCR_DIV_4 && $past(pri_q[9:8]) == TCR_DIV_4
      |=> s_gap4) else $error("sample spacing wrong");
endmodule // tcr_monitor
bind tcr_control tcr_monitor mon_u (.*);
`default_nettype wire

// [bench/tcr_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module tcr_control_bench
   import tcr_pkg::*;
;
   // ------------------------------
   // Stimulus and observed signals
   // ------------------------------
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        main_output_on_i = 1'b0;
   logic        trigger_input_i = 1'b0;
   logic [1:0]  lock_level_i = 2'h0;
   logic [3:0]  channel_ctrl_i = 4'h0;
   logic [6:0]  e = 7'h00;
   logic [7:0]  addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic [15:0] reload_value_i = 16'h0000;
   logic [15:0] prescale_value_i = 16'h0000;
   logic [15:0] channel_compare_value_i = 16'h0000;
   logic [15:0] rdata_o, reload_active_o, prescale_active_o, compare_active_o;
   logic [3:0]  channel_ctrl_active_o;
   logic        count_run_o, update_event_signal_o, update_request_o, channel_dma_request_o;
   logic        sample_en_o, primary_channel_output_o, complement_channel_output_o;
   int          num_errors = 0;
   int          n_tests = 0;
   int          n;
   tcr_control dut_u (
      .overflow_i             (e[0]),
      .update_generate_bit_i  (e[1]),
      .slave_update_i         (e[2]),
      .trigger_start_i        (e[3]),
      .commutation_generate_i (e[4]),
      .compare_event_i        (e[5]),
      .reload_write_i         (e[6]),
      .*
   );
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // ------------------------------
   // Access and compare tasks
   // ------------------------------
   task automatic ck(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic ckb(input string nm, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %b got %b", nm, exp, got);
      end
   endtask
   task automatic count_en();
      repeat (8) @(posedge clk_sys_i);
      n = 0;
      repeat (40) begin
         @(posedge clk_sys_i);
         #1;
         n += sample_en_o;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      ck("rdata", exp, rdata_o);
   endtask
   task automatic pe(input logic [6:0] m);
      @(posedge clk_sys_i);
      e <= m;
      @(posedge clk_sys_i);
      e <= 7'h00;
      #1;
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------
   // Test sequence
   // ------------------------------
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(TCR_OFS_PRIMARY, TCR_PRIMARY_RST);
      rd(TCR_OFS_SECONDARY, TCR_SECONDARY_RST);
      wr(8'h00, 16'hffff);
      rd(8'h00, TCR_PRIMARY_MASK);
      wr(8'h04, 16'hffff);
      rd(8'h04, TCR_SECONDARY_MASK);
      wr(8'h08, 16'hffff);
      rd(8'h08, 16'h0000);
      lock_level_i <= 2'h1;
      wr(8'h04, 16'h0000);
      rd(8'h04, 16'h0300);
      ckb("idle_p", 1'b1, primary_channel_output_o);
      ckb("idle_c", 1'b1, complement_channel_output_o);
      main_output_on_i <= 1'b1;
      #1;
      ckb("idle_p", 1'b0, primary_channel_output_o);
      ckb("idle_c", 1'b0, complement_channel_output_o);
      main_output_on_i <= 1'b0;
      lock_level_i <= 2'h0;
      wr(8'h04, 16'h0100);
      @(posedge clk_sys_i);
      #1;
      ckb("idle_p", 1'b1, primary_channel_output_o);
      ckb("idle_c", 1'b0, complement_channel_output_o);
      wr(8'h00, 16'h0000);
      ckb("run", 1'b0, count_run_o);
      wr(8'h00, 16'h0001);
      ckb("run", 1'b1, count_run_o);
      wr(8'h00, 16'h0000);
      pe(7'h08);
      ckb("run", 1'b1, count_run_o);
      wr(8'h00, 16'h0089);
      reload_value_i <= 16'h1234;
      prescale_value_i <= 16'h0005;
      channel_compare_value_i <= 16'h0007;
      pe(7'h40);
      ck("reload", 16'h0000, reload_active_o);
      pe(7'h01);
      ckb("event", 1'b1, update_event_signal_o);
      ck("reload", 16'h1234, reload_active_o);
      ck("prescale", 16'h0005, prescale_active_o);
      ck("compare", 16'h0007, compare_active_o);
      ckb("run", 1'b0, count_run_o);
      wr(8'h00, 16'h0000);
      reload_value_i <= 16'h4321;
      pe(7'h40);
      ck("reload", 16'h4321, reload_active_o);
      wr(8'h00, 16'h0002);
      pe(7'h02);
      ckb("event", 1'b0, update_event_signal_o);
      wr(8'h00, 16'h0004);
      pe(7'h04);
      ckb("event", 1'b1, update_event_signal_o);
      ckb("request", 1'b0, update_request_o);
      pe(7'h01);
      ckb("request", 1'b1, update_request_o);
      wr(8'h00, 16'h0000);
      pe(7'h02);
      ckb("request", 1'b1, update_request_o);
      pe(7'h20);
      ckb("dma", 1'b1, channel_dma_request_o);
      wr(8'h04, 16'h0008);
      pe(7'h20);
      ckb("dma", 1'b0, channel_dma_request_o);
      pe(7'h01);
      ckb("dma", 1'b1, channel_dma_request_o);
      wr(8'h04, 16'h0001);
      channel_ctrl_i <= 4'h5;
      pe(7'h00);
      ck("ctrl", 16'h0000, {12'h000, channel_ctrl_active_o});
      pe(7'h10);
      ck("ctrl", 16'h0005, {12'h000, channel_ctrl_active_o});
      wr(8'h04, 16'h0005);
      channel_ctrl_i <= 4'ha;
      trigger_input_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      #1;
      ck("ctrl", 16'h000a, {12'h000, channel_ctrl_active_o});
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(TCR_OFS_SECONDARY, TCR_SECONDARY_RST);
      wr(8'h00, 16'h0200);
      count_en();
      ck("sample", 16'h000a, n[15:0]);
      wr(8'h00, 16'h0100);
      count_en();
      ck("sample", 16'h0014, n[15:0]);
      wr(8'h00, 16'h0000);
      count_en();
      ck("sample", 16'h0028, n[15:0]);
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      num_errors++;
      end_of_test();
   end
endmodule // tcr_control_bench
`default_nettype wire
